// ### src/rissl_top.sv
// Purpose: reference buffer, source select and status edge-rate registers
// Assumes: AHB-Lite slave with zero wait states, word accesses only
// Notes:   pin level code and valid flags come from outside, synchronised
//
// Our own choice: the AHB-Lite register port.
module rissl_top (
  input  wire logic        ref_clk,          // 40 MHz clock
  input  wire logic        rst_b,            // synchronous reset, active low
  input  wire logic        hsel,             // slave select
  input  wire logic [31:0] haddr,            // byte address
  input  wire logic [1:0]  htrans,           // transfer type
  input  wire logic        hwrite,           // write when high
  input  wire logic [2:0]  hsize,            // transfer size
  input  wire logic [31:0] hwdata,           // write data
  input  wire logic        hready,           // bus ready
  output logic             hreadyout,        // slave ready
  output logic             hresp,            // response, always okay
  output logic      [31:0] hrdata,           // read data
  input  wire logic        priRefValid,      // primary reference present
  input  wire logic        secRefValid,      // secondary reference present
  input  wire logic [1:0]  refChoicePinLvl,  // three-level pin comparator
  output rissl_pkg::rissl_cfg_t refCfg       // configuration to the path
);
  import rissl_pkg::*;

  logic       wrPend;
  logic [7:0] wrIdx;
  logic [1:0] srcSel;
  logic [1:0] selRsv;
  logic [1:0] pinPrev;
  logic [1:0] pinLvl;
  logic [3:0] syncd;
  rissl_ref_t curRef;
  rissl_ref_t next_ref;
  rissl_cfg_t next_cfg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // bus address phase decode
  wire       addrOk   = hsel && hready && htrans[1];
  wire [7:0] apIdx    = haddr[9:2];
  wire       apMapped = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
  wire       wordAcc  = hsize == HSIZE_WORD;
  wire       rdTake   = addrOk && !hwrite;

  assign hreadyout = 1'h1;
  assign hresp     = HRESP_OKAY;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wrPend <= 1'h0;
      wrIdx  <= 8'h00;
    end else begin
      wrPend <= addrOk && hwrite && wordAcc && apMapped;
      wrIdx  <= apIdx;
    end
  end

  // data phase write strobes
  wire wrEdge = wrPend && (wrIdx == IDX_STAT_EDGE);
  wire wrSel  = wrPend && (wrIdx == IDX_REF_SEL);
  wire wrCtl  = wrPend && (wrIdx == IDX_SWITCH_CTL);

  wire [1:0] wEdge1  = hwdata[EDGE1_LSB +: 2];
  wire [1:0] wEdge0  = hwdata[EDGE0_LSB +: 2];
  wire [1:0] wSecBuf = hwdata[SECBUF_LSB +: 2];
  wire [1:0] wPriBuf = hwdata[PRIBUF_LSB +: 2];
  wire       wBypass = hwdata[BYPASS_BIT];

  wire [1:0] next_srcSel = wrSel ? hwdata[SRCSEL_LSB +: 2] : srcSel; // RULE5
  wire [1:0] next_selRsv = wrSel ? hwdata[SELRSV_LSB +: 2] : selRsv;

  // pin levels and valid flags cross in
  rissl_sync2 #(
    .W (4)
  ) u_sync (
    .clk   (ref_clk),
    .rst_b (rst_b),
    .din   ({refChoicePinLvl, secRefValid, priRefValid}),
    .dout  (syncd)
  );

  wire       priOk   = syncd[0];
  wire       secOk   = syncd[1];
  wire [1:0] pinSamp = syncd[3:2];

  // pin code taken only when two samples agree, so torn codes are dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pinPrev <= PIN_LOW;
      pinLvl  <= PIN_LOW;
    end else begin
      pinPrev <= pinSamp;
      if (pinSamp == pinPrev) begin
        pinLvl <= pinSamp;
      end
    end
  end

  // pin mode decode; unused comparator code counts as high
  wire [1:0] pinMode = (pinLvl == PIN_LOW) ? SRC_PRI :
                       (pinLvl == PIN_MID) ? SRC_SEC : SRC_AUTO; // RULE6
  wire [1:0] effMode = (srcSel == SRC_PIN) ? pinMode : srcSel;   // RULE5

  always_comb begin
    next_ref = curRef;
    case (effMode)
      SRC_PRI: next_ref = REF_PRI;
      SRC_SEC: next_ref = REF_SEC;
      SRC_AUTO: begin
        unique case (curRef)
          REF_PRI: if (!priOk) next_ref = REF_SEC;  // RULE9
          REF_SEC: if (priOk) next_ref = REF_PRI;   // RULE9
          default: next_ref = REF_PRI;
        endcase
      end
      default: next_ref = curRef;
    endcase
  end

  always_comb begin
    next_cfg = refCfg;
    if (wrEdge) begin
      next_cfg.stat1EdgeRateSel = wEdge1;  // RULE1
      next_cfg.stat0EdgeRateSel = wEdge0;  // RULE2
    end
    if (wrSel) begin
      next_cfg.secondRefBufMode = wSecBuf; // RULE3
      next_cfg.firstRefBufMode  = wPriBuf; // RULE4
    end
    if (wrCtl) begin
      next_cfg.refSwitchBypass = wBypass;  // RULE8
    end
    next_cfg.firstRefBufEn  = (next_cfg.firstRefBufMode == BUF_SINGLE) ||
                              (next_cfg.firstRefBufMode == BUF_DIFF); // RULE4
    next_cfg.secondRefBufEn = next_cfg.secondRefBufMode != BUF_OFF;  // RULE3
    next_cfg.loopRefSecond  = next_ref == REF_SEC;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      refCfg <= RST_CFG;
      srcSel <= RST_SRCSEL;
      selRsv <= RST_SELRSV;
      curRef <= REF_PRI;
    end else begin
      refCfg <= next_cfg;
      srcSel <= next_srcSel;
      selRsv <= next_selRsv;
      curRef <= next_ref;
    end
  end

  // writable read words from next values so a read right after a write sees it; status word from current values
  wire [31:0] edgeWord = {24'h0, 4'h0, next_cfg.stat1EdgeRateSel,
                          next_cfg.stat0EdgeRateSel};            // RULE7
  wire [31:0] selWord  = {24'h0, next_cfg.secondRefBufMode,
                          next_cfg.firstRefBufMode, next_selRsv, next_srcSel};
  wire [31:0] ctlWord  = {24'h0, next_cfg.refSwitchBypass, 7'h0};
  wire [31:0] statWord = {25'h0, effMode, pinLvl, secOk, priOk,
                          curRef == REF_SEC};
  wire [31:0] rdWord   = !apMapped ? 32'h0 :
                         (apIdx == IDX_STAT_EDGE)  ? edgeWord :
                         (apIdx == IDX_REF_SEL)    ? selWord  :
                         (apIdx == IDX_SWITCH_CTL) ? ctlWord  :
                         (apIdx == IDX_REF_STATUS) ? statWord : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      hrdata <= 32'h0;
    end else if (rdTake) begin
      hrdata <= rdWord;
    end
  end

  // checks
  property p_edge1_write;
    wrEdge |=> refCfg.stat1EdgeRateSel == $past(wEdge1);
  endproperty
  a_edge1_write: assert property (p_edge1_write) // RULE1
    else $error("status 1 edge rate not loaded");

  property p_edge0_write;
    wrEdge ##1 !wrEdge |-> refCfg.stat0EdgeRateSel == $past(wEdge0);
  endproperty
  a_edge0_write: assert property (p_edge0_write) // RULE2
    else $error("status 0 edge rate not held");

  property p_sec_off;
    wrSel && (wSecBuf == BUF_OFF) |=> !refCfg.secondRefBufEn;
  endproperty
  a_sec_off: assert property (p_sec_off) // RULE3
    else $error("secondary buffer not disabled");

  property p_pri_en;
    refCfg.firstRefBufEn == (refCfg.firstRefBufMode[1] == 1'h0);
  endproperty
  a_pri_en: assert property (p_pri_en) // RULE4
    else $error("primary buffer enable wrong");

  property p_forced_pri;
    (srcSel == SRC_PRI) [*2] |-> !refCfg.loopRefSecond;
  endproperty
  a_forced_pri: assert property (p_forced_pri) // RULE5
    else $error("forced primary not followed");

  property p_pin_mid;
    (srcSel == SRC_PIN) && (pinLvl == PIN_MID) |=> refCfg.loopRefSecond;
  endproperty
  a_pin_mid: assert property (p_pin_mid) // RULE6
    else $error("pin mid level did not pick secondary");

  property p_rsv_zero;
    rdTake && apMapped && (apIdx == IDX_STAT_EDGE) |=> hrdata[7:4] == 4'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) // RULE7
    else $error("reserved edge-rate bits not zero");

  property p_bypass;
    wrCtl |=> refCfg.refSwitchBypass == $past(wBypass);
  endproperty
  a_bypass: assert property (p_bypass) // RULE8
    else $error("bypass bit not loaded");

  property p_auto_back;
    (effMode == SRC_AUTO) && priOk |=> !refCfg.loopRefSecond;
  endproperty
  a_auto_back: assert property (p_auto_back) // RULE9
    else $error("automatic mode left primary while valid");

  property p_auto_fall;
    (effMode == SRC_AUTO) && !priOk |=> refCfg.loopRefSecond;
  endproperty
  a_auto_fall: assert property (p_auto_fall) // RULE9
    else $error("automatic mode kept lost primary");

  c_pin_mid:  cover property ((srcSel == SRC_PIN) && (pinLvl == PIN_MID));
  c_fallback: cover property ((effMode == SRC_AUTO) && !priOk ##1 priOk);
  c_stat_rd:  cover property (rdTake && (apIdx == IDX_REF_STATUS));
  c_bypass:   cover property (wrCtl && wBypass);

endmodule // rissl_top

// ### src/rissl_pkg.sv
// Purpose: constants, codes and carrier types of the reference select block
// Assumes: registers sit on an AHB-Lite word bus, byte address = 4 * index
// Notes:   reserved edge-rate bits are not stored and read as zero
//
// How it works
// RULE1 - two-bit edge rate for status output 1: 0 fast, 2 slow, reset 0
// RULE2 - two-bit edge rate for status output 0: 0 fast, 2 slow, reset 0
// RULE3 - secondary buffer: single, diff, crystal, off; resets to crystal
// RULE4 - primary buffer: single, diff, codes 2 and 3 off; resets to diff
// RULE5 - source select: 0 auto, 1 pin, 2 primary, 3 secondary; reset 1
// RULE6 - in pin mode: low primary, mid secondary, high automatic
// RULE7 - upper four edge-rate bits reserved, not stored, read as zero
// RULE8 - switching goes through glitch-free mux unless bypass bit is one
// RULE9 - automatic: primary while valid, secondary when lost, back when valid
package rissl_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STAT_EDGE  = 8'h31;
  localparam logic [7:0] IDX_REF_SEL    = 8'h32;
  localparam logic [7:0] IDX_SWITCH_CTL = 8'h33;
  localparam logic [7:0] IDX_REF_STATUS = 8'h34;

  // field positions
  localparam int EDGE1_LSB  = 2;
  localparam int EDGE0_LSB  = 0;
  localparam int SECBUF_LSB = 6;
  localparam int PRIBUF_LSB = 4;
  localparam int SELRSV_LSB = 2;
  localparam int SRCSEL_LSB = 0;
  localparam int BYPASS_BIT = 7;

  // field codes
  localparam logic [1:0] EDGE_FAST  = 2'h0;
  localparam logic [1:0] EDGE_SLOW  = 2'h2;
  localparam logic [1:0] BUF_SINGLE = 2'h0;
  localparam logic [1:0] BUF_DIFF   = 2'h1;
  localparam logic [1:0] BUF_XTAL   = 2'h2;
  localparam logic [1:0] BUF_OFF    = 2'h3;
  localparam logic [1:0] SRC_AUTO   = 2'h0;
  localparam logic [1:0] SRC_PIN    = 2'h1;
  localparam logic [1:0] SRC_PRI    = 2'h2;
  localparam logic [1:0] SRC_SEC    = 2'h3;
  localparam logic [1:0] PIN_LOW    = 2'h0;
  localparam logic [1:0] PIN_MID    = 2'h1;
  localparam logic [1:0] PIN_HIGH   = 2'h2;

  // reset values
  localparam logic [1:0] RST_SELRSV = 2'h1;
  localparam logic [1:0] RST_SRCSEL = SRC_PIN;

  // bus constants
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'h0;

  typedef enum logic [1:0] {
    REF_PRI = 2'b01,
    REF_SEC = 2'b10
  } rissl_ref_t;

  typedef struct packed {
    logic [1:0] stat1EdgeRateSel;
    logic [1:0] stat0EdgeRateSel;
    logic [1:0] secondRefBufMode;
    logic [1:0] firstRefBufMode;
    logic       firstRefBufEn;
    logic       secondRefBufEn;
    logic       refSwitchBypass;
    logic       loopRefSecond;
  } rissl_cfg_t;

  localparam rissl_cfg_t RST_CFG = '{
    stat1EdgeRateSel: EDGE_FAST,
    stat0EdgeRateSel: EDGE_FAST,
    secondRefBufMode: BUF_XTAL,
    firstRefBufMode:  BUF_DIFF,
    firstRefBufEn:    1'h1,
    secondRefBufEn:   1'h1,
    refSwitchBypass:  1'h0,
    loopRefSecond:    1'h0
  };

endpackage

// ### src/rissl_sync2.sv
// Purpose: two-stage synchroniser for a bundle of slow pin levels
// Assumes: each bit is a level held far longer than a clock period
// Notes:   first stage feeds the second stage only
module rissl_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,    // sampling clock
  input  wire logic         rst_b,  // synchronous reset, active low
  input  wire logic [W-1:0] din,    // asynchronous levels
  output logic      [W-1:0] dout    // synchronised levels
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // rissl_sync2

// ### sim/rissl_ref_src.sv
// Purpose: reference sources and select pin outside the block
// Assumes: bench drives the wanted levels just after a rising edge
// Notes:   slow mode delays primary valid changes by three more cycles
module rissl_ref_src (
  input  wire logic       ref_clk,          // system clock
  input  wire logic       priOn,            // primary source running
  input  wire logic       secOn,            // secondary source running
  input  wire logic       slow,             // slow lock behaviour
  input  wire logic [1:0] lvlReq,           // wanted pin level
  output logic            priRefValid,      // primary present
  output logic            secRefValid,      // secondary present
  output logic      [1:0] refChoicePinLvl   // pin comparator code
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] priDly;
  initial begin
    priDly          = 3'h0;
    priRefValid     = 1'b0;
    secRefValid     = 1'b0;
    refChoicePinLvl = 2'h0;
  end
  always @(posedge ref_clk) begin
    priDly          <= {priDly[1:0], priOn};
    priRefValid     <= slow ? priDly[2] : priOn;
    secRefValid     <= secOn;
    refChoicePinLvl <= lvlReq;
  end
endmodule // rissl_ref_src

// ### sim/tb_ref_input_select_and_status_slew.sv
// Purpose: self-checking bench of the reference select block
// Assumes: zero wait state slave, synced inputs settle in a few edges
// Notes:   source select cases run from one table
module tb_ref_input_select_and_status_slew;
  import rissl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0, lvlReq = 2'h0;
  logic [2:0] hsize = 3'h2, sz = 3'h2;
  logic hreadyout, hresp, priOn = 1'b1, secOn = 1'b1, slow = 1'b0;
  logic priRefValid, secRefValid;
  logic [1:0] refChoicePinLvl;
  rissl_cfg_t refCfg;
  wire hready = hreadyout;
  int n_mismatch = 0, n_checks = 0;
  rissl_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .priRefValid(priRefValid),
    .secRefValid(secRefValid), .refChoicePinLvl(refChoicePinLvl),
    .refCfg(refCfg));
  rissl_ref_src src (.ref_clk(ref_clk), .priOn(priOn), .secOn(secOn),
    .slow(slow), .lvlReq(lvlReq), .priRefValid(priRefValid),
    .secRefValid(secRefValid), .refChoicePinLvl(refChoicePinLvl));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= sz;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    r = hrdata;
    chk(32'(hresp), 32'(HRESP_OKAY), "hresp");
    // written fields show one edge after the data phase
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [31:0] a, exp, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(r, exp, nm);
  endtask
  task automatic t_reset;
    rd(32'hC4, 32'h00, "edge reg");
    rd(32'hC8, 32'h95, "sel reg");
    chk(32'(refCfg), 32'(RST_CFG), "cfg");
    $display("test reset done");
  endtask
  task automatic t_edge;
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, 32'hC4, 32'(8'hF0 | (c << 2) | (3 - c)));
      chk(32'(refCfg.stat1EdgeRateSel), 32'(c), "edge1");
      chk(32'(refCfg.stat0EdgeRateSel), 32'(3 - c), "edge0");
      rd(32'hC4, 32'((c << 2) | (3 - c)), "edge rd");
    end
    sz = 3'h0;
    xfer(1'b1, 32'hC4, 32'h0);
    sz = 3'h2;
    rd(32'hC4, 32'h0C, "byte wr");
    $display("test edge done");
  endtask
  task automatic t_buf;
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, 32'hC8, 32'((m << 6) | (m << 4) | 5));
      chk(32'(refCfg.secondRefBufMode), 32'(m), "sec mode");
      chk(32'(refCfg.secondRefBufEn), 32'(m != 3), "sec en");
      chk(32'(refCfg.firstRefBufMode), 32'(m), "pri mode");
      chk(32'(refCfg.firstRefBufEn), 32'(m < 2), "pri en");
    end
    xfer(1'b1, 32'hCC, 32'h80);
    chk(32'(refCfg.refSwitchBypass), 32'h1, "bypass");
    xfer(1'b1, 32'hCC, 32'h00);
    chk(32'(refCfg.refSwitchBypass), 32'h0, "bypass");
    rd(32'h100, 32'h0, "unmapped");
    $display("test buffers done");
  endtask
  task automatic t_src;
    logic [1:0] s [9] = '{2, 3, 1, 1, 1, 1, 0, 0, 0};
    logic [1:0] l [9] = '{0, 0, 0, 1, 2, 2, 0, 0, 0};
    logic       p [9] = '{0, 1, 0, 1, 1, 0, 1, 0, 1};
    logic       e [9] = '{0, 1, 0, 1, 0, 1, 0, 1, 0};
    slow <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      xfer(1'b1, 32'hC8, 32'h94 | 32'(s[i]));
      lvlReq <= l[i];
      priOn  <= p[i];
      repeat (14) @(posedge ref_clk);
      chk(32'(refCfg.loopRefSecond), 32'(e[i]), "loop src");
      if (s[i] == SRC_PIN) begin
        chk(32'(refCfg.loopRefSecond), 32'(e[i]), "pin");
      end
      if (s[i] == SRC_AUTO) begin
        chk(32'(refCfg.loopRefSecond), 32'(e[i]), "auto");
      end
    end
    rd(32'hD0, 32'h06, "status");
    secOn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(32'hD0, 32'h02, "status sec lost");
    $display("test source done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_edge;
    t_buf;
    t_src;
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    end_sim;
  end
endmodule // tb_ref_input_select_and_status_slew
